// [logic/rtcs_pkg.sv]
// Purpose: shared constants of the clock control and status block
// Assumes: 8-bit register port, one system clock
// Notes:   register offsets are word indices on the plain register port
package rtcs_pkg;

  // ==========================================================
  // bus geometry
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 4;
  localparam int CNT_BYTES = 5;
  localparam int CNT_W     = 40;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CNT0     = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_MAT0     = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'hB;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'hC;

  // ==========================================================
  // control register fields
  localparam int CTRL_BLK_RST = 7;
  localparam int CTRL_RUN     = 6;
  localparam int CTRL_VR      = 5;
  localparam int CTRL_MODE_HI = 4;
  localparam int CTRL_MODE_LO = 3;
  localparam int CTRL_COM     = 2;
  localparam int CTRL_CLR_N   = 1;
  localparam int CTRL_OSC_SEL = 0;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;

  // ==========================================================
  // interrupt fields
  localparam int IRQ_W     = 2;
  localparam int IRQ_MATCH = 0;
  localparam int IRQ_WRAP  = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // ==========================================================
  // timing
  localparam int PRESCALE_DIV = 64;
  localparam int BLK_RST_DLY  = 2;
  localparam int SYNC_STAGES  = 3;

endpackage

// [logic/rtcs_edge_sync.sv]
// Purpose: bring the timekeeping clock pin into the system clock domain
// Assumes: pin toggles far slower than the system clock
// Notes:   one-cycle pulse per accepted rising edge
`timescale 1ns/1ps

module rtcs_edge_sync (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // pin side
  input  wire logic pin_in,
  // edge pulse
  output logic      rise_o
);
  import rtcs_pkg::*;

  logic [SYNC_STAGES-1:0] sync_q;
  logic [SYNC_STAGES-1:0] sync_d;
  logic                   lvl_q;
  logic                   lvl_d;
  logic                   rise_q;
  logic                   rise_d;

  // ==========================================================
  // three stages; a change counts once the last two agree
  always_comb begin
    sync_d = {sync_q[SYNC_STAGES-2:0], pin_in};
    lvl_d  = lvl_q;
    rise_d = 1'b0;
    if (sync_q[1] == sync_q[2]) begin
      lvl_d  = sync_q[2];
      rise_d = sync_q[2] & ~lvl_q;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync_q <= '0;
      lvl_q  <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      lvl_q  <= lvl_d;
      rise_q <= rise_d;
    end
  end

  assign rise_o = rise_q;

endmodule

// [logic/rtcs_prescale.sv]
// Purpose: divide timekeeping edges into counter increments
// Assumes: tick is a one-cycle pulse
// Notes:   count restarts from zero whenever enable drops
`timescale 1ns/1ps

module rtcs_prescale #(
  parameter int DIV = rtcs_pkg::PRESCALE_DIV
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // control
  input  wire logic en,
  input  wire logic tick,
  // increment strobe
  output logic      inc_o
);
  import rtcs_pkg::*;

  localparam int PW = $clog2(DIV);
  localparam logic [PW-1:0] LAST = PW'(DIV - 1);

  if (DIV < 2 || (DIV & (DIV - 1)) != 0) begin : g_chk
    $error("prescaler divide must be a power of two of at least two");
  end

  logic [PW-1:0] cnt_q;
  logic [PW-1:0] cnt_d;
  logic          inc_q;
  logic          inc_d;

  // ==========================================================
  // divide by DIV while enabled
  always_comb begin
    cnt_d = cnt_q;
    inc_d = 1'b0;
    if (!en) begin
      cnt_d = '0;
    end else if (tick) begin
      cnt_d = cnt_q + 1'b1;
      inc_d = (cnt_q == LAST);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      inc_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      inc_q <= inc_d;
    end
  end

  assign inc_o = inc_q;

  // ==========================================================
  // checks
  property p_div_count;
    @(posedge clock) disable iff (!rst_b)
    inc_o |-> $past(cnt_q) == LAST && $past(tick) && $past(en);
  endproperty
  a_div_count: assert property (p_div_count)
    else $error("increment without full prescale count");

endmodule

// [logic/rtcs_ctrl.sv]
// Purpose: control/status register and 40-bit time counter
// Assumes: plain register port, read data one cycle after strobe
// Notes:   timekeeping clock arrives as a pin and is sampled
`timescale 1ns/1ps

module rtcs_ctrl (
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst_b,
  // register port
  input  wire logic [rtcs_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [rtcs_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [rtcs_pkg::DATA_W-1:0]  reg_rdata,
  // timekeeping clock pin
  input  wire logic                         timekeeping_clock,
  // regulator sequencer
  output logic                              match_flag_out,
  output logic                              match_wake_out,
  // crystal oscillator
  output logic      [1:0]                   osc_mode_out,
  output logic                              osc_select_out,
  // interrupt
  output logic                              irq
);
  import rtcs_pkg::*;

  typedef logic [CNT_W-1:0] rtcs_cnt_t;

  logic [DATA_W-1:0]      ctrl_q;
  logic [DATA_W-1:0]      ctrl_d;
  logic [BLK_RST_DLY-1:0] dly_q;
  logic [BLK_RST_DLY-1:0] dly_d;
  rtcs_cnt_t              cnt_q;
  rtcs_cnt_t              cnt_d;
  rtcs_cnt_t              mat_q;
  rtcs_cnt_t              mat_d;
  logic [IRQ_W-1:0]       stat_q;
  logic [IRQ_W-1:0]       stat_d;
  logic [IRQ_W-1:0]       mask_q;
  logic [IRQ_W-1:0]       mask_d;
  logic [DATA_W-1:0]      rdata_q;
  logic [DATA_W-1:0]      rdata_d;
  logic                   mflag_q;
  logic                   mflag_d;
  logic                   eq_q;
  logic                   core_rst;
  logic                   run_en;
  logic                   tick;
  logic                   inc;
  logic                   step;
  logic                   eq;
  logic                   mat_nz;
  logic                   cnt_wr;
  logic                   mat_wr;
  logic [IRQ_W-1:0]       evt;

  // ==========================================================
  // address decode helpers
  function automatic logic in_bytes(logic [ADDR_W-1:0] a,
                                    logic [ADDR_W-1:0] base);
    in_bytes = (a >= base) && (a < base + ADDR_W'(CNT_BYTES));
  endfunction

  function automatic logic [2:0] byte_idx(logic [ADDR_W-1:0] a,
                                          logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] d;
    d = a - base;
    byte_idx = d[2:0];
  endfunction

  // ==========================================================
  // block reset and enables
  // delayed release
  assign core_rst = ctrl_q[CTRL_BLK_RST] | (|dly_q);
  assign run_en   = ctrl_q[CTRL_RUN] & ~core_rst;
  assign eq       = (cnt_q == mat_q);
  assign mat_nz   = |mat_q;
  assign cnt_wr   = reg_wr & in_bytes(reg_addr, ADDR_CNT0) & ~run_en;
  assign mat_wr   = reg_wr & in_bytes(reg_addr, ADDR_MAT0);
  assign step     = inc & run_en;

  rtcs_edge_sync u_sync (
    .clock  (clock),
    .rst_b  (rst_b),
    .pin_in (timekeeping_clock),
    .rise_o (tick)
  );

  // prescaler halted and cleared when run drops
  rtcs_prescale #(
    .DIV (PRESCALE_DIV)
  ) u_pre (
    .clock (clock),
    .rst_b (rst_b),
    .en    (run_en),
    .tick  (tick),
    .inc_o (inc)
  );

  // ==========================================================
  // control register and reset release
  always_comb begin
    ctrl_d = ctrl_q;
    dly_d  = {dly_q[BLK_RST_DLY-2:0], ctrl_q[CTRL_BLK_RST]};
    if (reg_wr && reg_addr == ADDR_CTRL) begin
      ctrl_d = reg_wdata;
    end
  end

  // ==========================================================
  // counter and match value
  always_comb begin
    cnt_d = cnt_q;
    mat_d = mat_q;
    if (mat_wr) begin
      mat_d[{byte_idx(reg_addr, ADDR_MAT0), 3'h0} +: DATA_W] = reg_wdata;
    end
    if (core_rst || !ctrl_q[CTRL_CLR_N]) begin
      cnt_d = '0;
    end else if (cnt_wr) begin
      cnt_d[{byte_idx(reg_addr, ADDR_CNT0), 3'h0} +: DATA_W] = reg_wdata;
    end else if (step) begin
      if (ctrl_q[CTRL_COM] && eq && mat_nz) begin
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // match outputs and interrupts
  always_comb begin
    mflag_d = ctrl_q[CTRL_VR] & eq & ~core_rst;
    evt = '0;
    evt[IRQ_MATCH] = eq & ~eq_q & ~core_rst;
    evt[IRQ_WRAP]  = step & (&cnt_q) & ~core_rst & ctrl_q[CTRL_CLR_N];
    stat_d = stat_q;
    mask_d = mask_q;
    if (reg_wr && reg_addr == ADDR_IRQ_STAT) begin
      stat_d = stat_q & ~reg_wdata[IRQ_W-1:0];
    end
    if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
      mask_d = reg_wdata[IRQ_W-1:0];
    end
    // set wins over clear
    stat_d = stat_d | evt;
  end

  // ==========================================================
  // read data
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      if (reg_addr == ADDR_CTRL) begin
        rdata_d = ctrl_q;
      end else if (in_bytes(reg_addr, ADDR_CNT0)) begin
        rdata_d = cnt_q[{byte_idx(reg_addr, ADDR_CNT0), 3'h0} +: DATA_W];
      end else if (in_bytes(reg_addr, ADDR_MAT0)) begin
        rdata_d = mat_q[{byte_idx(reg_addr, ADDR_MAT0), 3'h0} +: DATA_W];
      end else if (reg_addr == ADDR_IRQ_STAT) begin
        rdata_d = {{(DATA_W-IRQ_W){1'b0}}, stat_q};
      end else if (reg_addr == ADDR_IRQ_MASK) begin
        rdata_d = {{(DATA_W-IRQ_W){1'b0}}, mask_q};
      end
    end
  end

  // ==========================================================
  // state registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q  <= CTRL_RESET;
      dly_q   <= '0;
      cnt_q   <= '0;
      mat_q   <= '0;
      stat_q  <= IRQ_RESET;
      mask_q  <= IRQ_RESET;
      rdata_q <= '0;
      mflag_q <= 1'b0;
      // counter and match both reset to zero, so they start out equal
      eq_q    <= 1'b1;
    end else begin
      ctrl_q  <= ctrl_d;
      dly_q   <= dly_d;
      cnt_q   <= cnt_d;
      mat_q   <= mat_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
      mflag_q <= mflag_d;
      eq_q    <= eq;
    end
  end

  assign reg_rdata      = rdata_q;
  assign match_flag_out = mflag_q;
  assign match_wake_out = mflag_q;
  assign osc_mode_out   = ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO];
  assign osc_select_out = ctrl_q[CTRL_OSC_SEL];
  assign irq            = |(stat_q & mask_q);

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_blk_release;
    $fell(ctrl_q[CTRL_BLK_RST]) |-> core_rst ##1 core_rst;
  endproperty
  a_blk_release: assert property (p_blk_release)
    else $error("block reset released too early");

  property p_run_gate;
    inc |-> $past(ctrl_q[CTRL_RUN]) && !$past(core_rst);
  endproperty
  a_run_gate: assert property (p_run_gate)
    else $error("counter step while not enabled");

  property p_stop_hold;
    !run_en && !cnt_wr && ctrl_q[CTRL_CLR_N] ##1 !core_rst
      |-> $stable(cnt_q);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stopped counter changed");

  property p_load_locked;
    run_en && !inc && ctrl_q[CTRL_CLR_N] && !ctrl_q[CTRL_BLK_RST]
      |=> cnt_q == $past(cnt_q);
  endproperty
  a_load_locked: assert property (p_load_locked)
    else $error("counter loaded while running");

  property p_match_out;
    ctrl_q[CTRL_VR] && eq && !core_rst |=> match_flag_out && match_wake_out;
  endproperty
  a_match_out: assert property (p_match_out)
    else $error("match outputs missed");

  property p_match_off;
    !ctrl_q[CTRL_VR] |=> !match_flag_out && !match_wake_out;
  endproperty
  a_match_off: assert property (p_match_off)
    else $error("match outputs high while disabled");

  property p_mode_out;
    reg_wr && reg_addr == ADDR_CTRL
      |=> osc_mode_out == $past(reg_wdata[CTRL_MODE_HI:CTRL_MODE_LO])
          && osc_select_out == $past(reg_wdata[CTRL_OSC_SEL]);
  endproperty
  a_mode_out: assert property (p_mode_out)
    else $error("oscillator outputs not following control");

  property p_com_clear;
    step && ctrl_q[CTRL_COM] && eq && mat_nz && ctrl_q[CTRL_CLR_N]
      && !core_rst |=> cnt_q == '0;
  endproperty
  a_com_clear: assert property (p_com_clear)
    else $error("counter not cleared on match");

  property p_com_zero;
    step && !mat_nz && ctrl_q[CTRL_CLR_N] && !core_rst
      |=> cnt_q == $past(cnt_q) + 1'b1;
  endproperty
  a_com_zero: assert property (p_com_zero)
    else $error("clear on match acted with zero match");

  property p_clr_n;
    !ctrl_q[CTRL_CLR_N] |=> cnt_q == '0;
  endproperty
  a_clr_n: assert property (p_clr_n)
    else $error("counter clear ignored");

  c_step:   cover property (inc ##1 cnt_q == 40'h00_0000_0001);
  c_match:  cover property (ctrl_q[CTRL_VR] ##1 match_wake_out);
  c_irq:    cover property (irq ##1 !irq);

endmodule

// [verif/rtcs_xtal_model.sv]
// Purpose: far side model, crystal pin and regulator wake input
// Assumes: pin half period of HALF system cycles, HALF at least 3
// Notes:   pin runs free; edges and wakes only ever count up
`timescale 1ns/1ps

module rtcs_xtal_model #(
  parameter int HALF = 4
) (
  // clock
  input  wire logic clock,
  // sequencer side
  input  wire logic match_wake_out,
  // crystal side
  output logic      timekeeping_clock,
  output int        edges,
  output int        wakes
);
  // ==========================================================
  // pin generator and wake counter
  int   ph;
  logic wake_q;

  initial begin
    timekeeping_clock = 1'b0;
    ph = 0;
    edges = 0;
    wakes = 0;
    wake_q = 1'b0;
  end

  always @(posedge clock) begin
    if (ph == HALF - 1) begin
      ph <= 0;
      timekeeping_clock <= ~timekeeping_clock;
      if (!timekeeping_clock) edges <= edges + 1;
    end else begin
      ph <= ph + 1;
    end
    wake_q <= match_wake_out;
    if (match_wake_out && !wake_q) wakes <= wakes + 1;
  end
endmodule

// [verif/tb_rtc_control_status_logic.sv]
// Purpose: self-checking bench of the control and status block
// Assumes: pin edges every 8 system cycles from the model
// Notes:   reads queue expected bytes, a monitor compares them
`timescale 1ns/1ps

module tb_rtc_control_status_logic;
  import rtcs_pkg::*;

  // ==========================================================
  // signals
  logic                 clock = 1'b0;
  logic                 rst_b = 1'b0;
  logic [ADDR_W-1:0]    reg_addr = '0;
  logic [DATA_W-1:0]    reg_wdata = '0;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [DATA_W-1:0]    reg_rdata;
  logic                 timekeeping_clock;
  logic                 match_flag_out;
  logic                 match_wake_out;
  logic [1:0]           osc_mode_out;
  logic                 osc_select_out;
  logic                 irq;
  logic                 rd_d = 1'b0;
  logic [CNT_W-1:0]     v;
  logic                 sel;
  logic [DATA_W-1:0]    exp_q[$];
  int                   edges;
  int                   wakes;
  int                   base;
  int                   failures = 0;
  int                   tests_run = 0;

  always #20 clock = ~clock;

  rtcs_ctrl DUT (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timekeeping_clock(timekeeping_clock),
    .match_flag_out(match_flag_out), .match_wake_out(match_wake_out),
    .osc_mode_out(osc_mode_out), .osc_select_out(osc_select_out),
    .irq(irq)
  );

  rtcs_xtal_model #(.HALF(4)) xtal (
    .clock(clock), .match_wake_out(match_wake_out),
    .timekeeping_clock(timekeeping_clock), .edges(edges), .wakes(wakes)
  );

  // ==========================================================
  // tasks
  task automatic wrap_up();
    // a read whose data never came back counts as a mismatch
    if (exp_q.size() != 0) failures++;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [CNT_W-1:0] s, input logic [CNT_W-1:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    reg_rd   <= 1'b0;
  endtask

  task automatic wr5(input logic [ADDR_W-1:0] b, input logic [CNT_W-1:0] d);
    for (int i = 0; i < CNT_BYTES; i++) wr(b + ADDR_W'(i), d[8*i+:8]);
  endtask

  task automatic rd5(input logic [ADDR_W-1:0] b, input logic [CNT_W-1:0] e);
    for (int i = 0; i < CNT_BYTES; i++) rd(b + ADDR_W'(i), e[8*i+:8]);
  endtask

  task automatic wait_e(input int n);
    int k;
    k = 0;
    while (edges - base < n && k < 20000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 20000) begin
      failures++;
      wrap_up();
    end
  endtask

  // ==========================================================
  // read monitor
  always @(posedge clock) rd_d <= reg_rd;

  always @(negedge clock) begin
    if (rd_d === 1'b1 && exp_q.size() > 0) chk(reg_rdata, exp_q.pop_front());
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    void'($urandom(32'hf1b6));
    rd(ADDR_CTRL, 8'h00);
    rd(ADDR_IRQ_MASK, 8'h00);
    rd(4'hF, 8'h00);
    for (int m = 0; m < 4; m++) begin
      sel = 1'($urandom());
      wr(ADDR_CTRL, {3'h0, 2'(m), 2'h0, sel});
      @(negedge clock);
      chk(osc_mode_out, m);
      chk(osc_select_out, sel);
      rd(ADDR_CTRL, {3'h0, 2'(m), 2'h0, sel});
    end
    // select cleared before sleep, set before standby
    wr(ADDR_CTRL, 8'h00);
    @(negedge clock);
    chk(osc_select_out, 1'b0);
    wr(ADDR_CTRL, 8'h01);
    @(negedge clock);
    chk(osc_select_out, 1'b1);
    v = {1'b0, 7'($urandom()), 32'($urandom())};
    wr(ADDR_CTRL, 8'h02);
    wr5(ADDR_CNT0, v);
    rd5(ADDR_CNT0, v);
    wr5(ADDR_MAT0, v + 40'h3);
    wr(ADDR_IRQ_MASK, 8'h01);
    base = edges;
    wr(ADDR_CTRL, 8'h66);
    wr(ADDR_CNT0, ~v[7:0]);
    rd(ADDR_CNT0, v[7:0]);
    wait_e(60);
    rd(ADDR_CNT0, v[7:0]);
    wait_e(70);
    rd5(ADDR_CNT0, v + 40'h1);
    wait_e(134);
    rd5(ADDR_CNT0, v + 40'h2);
    wait_e(198);
    chk(match_flag_out, 1'b1);
    chk(match_wake_out, 1'b1);
    chk(irq, 1'b1);
    rd(ADDR_IRQ_STAT, 8'h01);
    wr(ADDR_IRQ_STAT, 8'h01);
    @(negedge clock);
    chk(irq, 1'b0);
    wait_e(262);
    rd5(ADDR_CNT0, 40'h0);
    chk(match_flag_out, 1'b0);
    chk(wakes, 1);
    wait_e(326);
    wr(ADDR_CTRL, 8'h26);
    wait_e(420);
    rd5(ADDR_CNT0, 40'h1);
    wr(ADDR_CTRL, 8'h00);
    rd5(ADDR_CNT0, 40'h0);
    wr(ADDR_CTRL, 8'h02);
    wr5(ADDR_CNT0, {CNT_W{1'b1}});
    wr5(ADDR_MAT0, 40'h0);
    wr(ADDR_IRQ_STAT, 8'h03);
    wr(ADDR_IRQ_MASK, 8'h00);
    base = edges;
    wr(ADDR_CTRL, 8'h46);
    wait_e(70);
    rd5(ADDR_CNT0, 40'h0);
    rd(ADDR_IRQ_STAT, 8'h03);
    chk(irq, 1'b0);
    chk(match_flag_out, 1'b0);
    wr(ADDR_IRQ_MASK, 8'h02);
    @(negedge clock);
    chk(irq, 1'b1);
    wait_e(134);
    rd5(ADDR_CNT0, 40'h1);
    wr(ADDR_IRQ_STAT, 8'h03);
    @(negedge clock);
    chk(irq, 1'b0);
    wr(ADDR_CTRL, 8'hE6);
    rd(ADDR_CTRL, 8'hE6);
    rd5(ADDR_CNT0, 40'h0);
    chk(match_wake_out, 1'b0);
    wr(ADDR_CTRL, 8'h02);
    // a load inside the two-cycle release window is lost
    wr(ADDR_CNT0, 8'hA5);
    rd(ADDR_CNT0, 8'h00);
    repeat (4) @(posedge clock);
    wr(ADDR_CNT0, 8'h5A);
    rd(ADDR_CNT0, 8'h5A);
    repeat (3) @(posedge clock);
    wrap_up();
  end
endmodule
